// ---- design/ext_bus_pkg.sv ----
package ext_bus_pkg;

    // part flavour: which reset defaults and start address apply
    typedef enum logic [1:0] {
        VAR_ROM = 2'b00,
        VAR_ROMLESS_A = 2'b01,
        VAR_ROMLESS_B = 2'b10
    } variant_t;

    // register indices; every byte address is four times the index
    localparam logic [7:0] IDX_PORT0 = 8'h00;
    localparam logic [7:0] IDX_PORT1 = 8'h01;
    localparam logic [7:0] IDX_PORT3_CFG = 8'hf7;
    localparam logic [7:0] IDX_BUS_MODE = 8'hf8;
    localparam logic [11:0] ADDR_PORT0 = {2'b00, IDX_PORT0, 2'b00};
    localparam logic [11:0] ADDR_PORT1 = {2'b00, IDX_PORT1, 2'b00};
    localparam logic [11:0] ADDR_PORT3_CFG = {2'b00, IDX_PORT3_CFG, 2'b00};
    localparam logic [11:0] ADDR_BUS_MODE = {2'b00, IDX_BUS_MODE, 2'b00};
    localparam logic [11:0] ADDR_BUS_ADDR = 12'h400;
    localparam logic [11:0] ADDR_BUS_DATA = 12'h404;
    localparam logic [11:0] ADDR_CMD = 12'h408;
    localparam logic [11:0] ADDR_STATUS = 12'h40c;
    localparam logic [11:0] ADDR_OPCODE = 12'h410;

    // bus port mode fields
    localparam int unsigned MODE_P0LO_LSB = 0;
    localparam int unsigned MODE_STACK_INT = 2;
    localparam int unsigned MODE_P1_LSB = 3;
    localparam int unsigned MODE_EXT_TIMING = 5;
    localparam int unsigned P0_NIBBLE_STRIDE = 6;
    localparam int unsigned P3_DM_LSB = 3;
    localparam logic [1:0] PAIR_OUT = 2'b00;
    localparam logic [1:0] PAIR_IN = 2'b01;
    localparam logic [1:0] P1_AD = 2'b10;
    localparam logic [1:0] DM_SEL_A = 2'b10;
    localparam logic [1:0] DM_SEL_B = 2'b01;

    // command register fields
    localparam int unsigned CMD_LONG_BIT = 3;

    // values after reset, and fixed read values
    localparam logic [7:0] MODE_RST_ROM = 8'h6d;
    localparam logic [7:0] MODE_RST_A = 8'h75;
    localparam logic [7:0] MODE_RST_B = 8'h96;
    localparam logic [7:0] P3_CFG_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [15:0] PC_RST_ROM = 16'h000c;
    localparam logic [15:0] PC_RST_A = 16'h000c;
    localparam logic [15:0] PC_RST_B = 16'h0812;
    localparam logic [16:0] INT_ROM_RST = 17'h00800;
    localparam logic [7:0] INT_READ_VALUE = 8'hff;
    localparam logic [7:0] NOT_REG_VALUE = 8'hff;

    // timing in internal clock periods; internal clock is pclk / 2
    localparam int unsigned CLK_DIV = 2;
    localparam logic [1:0] ADDR_LAST = 2'd1;
    localparam logic [1:0] XFER_LAST_NORM = 2'd1;
    localparam logic [1:0] EXT_TICKS = 2'd2;
    localparam logic [1:0] XFER_LAST_EXT = XFER_LAST_NORM + EXT_TICKS;
    localparam logic [1:0] END_LAST = 2'd1;

    typedef enum logic [2:0] {
        CMD_NONE = 3'd0,
        CMD_FETCH = 3'd1,
        CMD_PROG_READ = 3'd2,
        CMD_PROG_WRITE = 3'd3,
        CMD_DATA_READ = 3'd4,
        CMD_DATA_WRITE = 3'd5,
        CMD_PUSH = 3'd6,
        CMD_POP = 3'd7
    } cmd_t;

    // gray along idle -> address -> transfer -> end -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_XFER = 2'b11,
        ST_END = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic address_strobe_n;
        logic data_strobe_n;
        logic read_write_n;
        logic [7:0] port0_out;
        logic [7:0] port0_oe;
        logic [7:0] port1_out;
        logic port1_oe;
        logic data_space_select_n;
        logic data_space_select_oe;
    } bus_pins_t;

endpackage : ext_bus_pkg

// ---- design/tick_divider.sv ----
`timescale 1ns/1ns
module tick_divider #(
    parameter int unsigned DIV = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    // one pulse every DIV clocks marks an internal clock period
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 8'(DIV - 1)) begin
            s_d.cnt = 8'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : tick_divider

// ---- design/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // a bit changes only once stages two and three agree
    always_comb begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.q = (s_q.s2 & s_q.s3) | (s_q.q & (s_q.s2 ^ s_q.s3));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.q;
endmodule : pin_sync

// ---- design/ext_bus_ctrl.sv ----
`timescale 1ns/1ns
// Contract
// - extended-timing mode bit adds two internal clock periods, stretching data strobe.
// - on-chip accesses keep normal timing regardless of extended timing.
// - ROM part resets with ports 0/1 inputs, internal stack, extended timing.
// - next opcode is fetched while the current instruction executes.
// - long or memory-referencing instructions flush the prefetched opcode.
// - internal clock period runs at half the input clock.
// - address strobe pulses low once at the start of every machine cycle.
// - write data valid by strobe fall; read data valid before strobe rise.
// - direction line low only for memory writes, high otherwise.
// - ROMless parts always use port 1 as multiplexed address/data bus.
// - ROMless parts start fetching at 000c and 0812 respectively.
// - mode bits select port 0 low and high nibbles as upper address.
// - port 0 reads ones in address nibbles; writes reach I/O nibble only.
// - first ROMless part leaves port 0 input; second drives address.
// - stack location bit picks register file or external data memory.
// - data-space select on port 3 line 4 for data loads, external stack.
// - machine cycles last six or eight internal clock periods.
// - port 1 address valid in first state only; port 0 address stable.
// - reads release the bus before strobe fall, capture before it rises.
module ext_bus_ctrl #(
    parameter ext_bus_pkg::variant_t VARIANT = ext_bus_pkg::VAR_ROM,
    parameter logic [16:0] INT_ROM_LIMIT = ext_bus_pkg::INT_ROM_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input ext_bus_pkg::apb_req_t apb_req,
    output ext_bus_pkg::apb_rsp_t apb_rsp,
    input wire logic [7:0] port0_in,
    input wire logic [7:0] port1_in,
    output ext_bus_pkg::bus_pins_t pins
);
    import ext_bus_pkg::*;

    typedef struct packed {
        apb_rsp_t rsp;
        bus_pins_t pins;
        logic [7:0] mode;
        logic [7:0] p3cfg;
        logic [7:0] p0_reg;
        logic [7:0] p1_reg;
        logic [15:0] pc;
        logic [15:0] bus_addr;
        logic [15:0] cyc_addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [7:0] opcode;
        logic [7:0] prefetch;
        logic pf_valid;
        logic busy;
        logic internal;
        logic ext;
        logic to_prefetch;
        cmd_t cmd;
        bus_state_t st;
        logic [1:0] cnt;
    } ctl_state_t;

    // reset defaults follow the part flavour
    localparam logic [7:0] MODE_RST =
        (VARIANT == VAR_ROM) ? MODE_RST_ROM :
        (VARIANT == VAR_ROMLESS_A) ? MODE_RST_A : MODE_RST_B;
    localparam logic [15:0] PC_RST =
        (VARIANT == VAR_ROM) ? PC_RST_ROM :
        (VARIANT == VAR_ROMLESS_A) ? PC_RST_A : PC_RST_B;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic tick;
    logic [15:0] pin_sync_q;
    logic [7:0] p0_pin;
    logic [7:0] p1_pin;
    logic p1_bus;
    logic dm_en;
    logic [1:0] pair;
    logic [31:0] rd;
    logic hit;
    logic setup;
    logic wr_take;
    logic go;
    cmd_t go_cmd;
    logic [15:0] go_addr;
    logic go_int;
    logic go_write;
    logic go_data;
    logic [1:0] xfer_last;
    cmd_t new_cmd;

    // internal clock period enable at half the pclk rate
    tick_divider #(
        .DIV(CLK_DIV)
    ) u_div (
        .clk(pclk),
        .rst_n(presetn),
        .tick(tick)
    );

    // port pins come from outside the clock domain
    pin_sync #(
        .WIDTH(16)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({port1_in, port0_in}),
        .q(pin_sync_q)
    );

    assign p0_pin = pin_sync_q[7:0];
    assign p1_pin = pin_sync_q[15:8];

    always_comb begin
        s_d = s_q;
        rd = 32'h0000_0000;
        hit = 1'b1;
        go = 1'b0;
        go_cmd = CMD_NONE;
        go_addr = s_q.bus_addr;
        go_int = 1'b0;
        go_write = 1'b0;
        go_data = 1'b0;
        pair = PAIR_IN;
        new_cmd = cmd_t'(apb_req.pwdata[2:0]);
        // ROMless parts keep port 1 as the bus whatever the mode says
        p1_bus = (VARIANT != VAR_ROM) ||
            (s_q.mode[MODE_P1_LSB +: 2] == P1_AD);
        dm_en = (s_q.p3cfg[P3_DM_LSB +: 2] == DM_SEL_A) ||
            (s_q.p3cfg[P3_DM_LSB +: 2] == DM_SEL_B);
        xfer_last = s_q.ext ? XFER_LAST_EXT : XFER_LAST_NORM;

        // register read decode, port views depend on the nibble modes
        case (apb_req.paddr)
            ADDR_PORT0: begin
                for (int n = 0; n < 2; n++) begin
                    pair = s_q.mode[P0_NIBBLE_STRIDE * n +: 2];
                    if (pair[1]) begin
                        rd[4 * n +: 4] = 4'hf;
                    end else if (pair == PAIR_OUT) begin
                        rd[4 * n +: 4] = s_q.p0_reg[4 * n +: 4];
                    end else begin
                        rd[4 * n +: 4] = p0_pin[4 * n +: 4];
                    end
                end
            end
            ADDR_PORT1: begin
                if (p1_bus) begin
                    rd[7:0] = NOT_REG_VALUE;
                end else if (s_q.mode[MODE_P1_LSB +: 2] == PAIR_OUT) begin
                    rd[7:0] = s_q.p1_reg;
                end else begin
                    rd[7:0] = p1_pin;
                end
            end
            ADDR_PORT3_CFG, ADDR_BUS_MODE: rd = 32'h0000_0000; // write only
            ADDR_BUS_ADDR: rd[15:0] = s_q.bus_addr;
            ADDR_BUS_DATA: rd[15:0] = {s_q.wdata, s_q.rdata};
            ADDR_CMD: rd[2:0] = s_q.cmd;
            ADDR_STATUS: begin
                rd = {s_q.pc, 13'h0000, s_q.internal, s_q.pf_valid,
                    s_q.busy};
            end
            ADDR_OPCODE: rd[15:0] = {s_q.prefetch, s_q.opcode};
            default: hit = 1'b0;
        endcase

        // apb: answer registered in setup, one access cycle, no waits
        setup = apb_req.psel && !apb_req.penable;
        wr_take = apb_req.psel && apb_req.penable && s_q.rsp.pready &&
            apb_req.pwrite && hit;
        s_d.rsp.pready = setup;
        if (setup) begin
            s_d.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
            s_d.rsp.pslverr = !hit;
        end

        // register writes; port 0 address nibbles are not writable
        if (wr_take) begin
            case (apb_req.paddr)
                ADDR_PORT0: begin
                    for (int n = 0; n < 2; n++) begin
                        if (!s_q.mode[P0_NIBBLE_STRIDE * n + 1]) begin
                            s_d.p0_reg[4 * n +: 4] =
                                apb_req.pwdata[4 * n +: 4];
                        end
                    end
                end
                ADDR_PORT1: begin
                    if (!p1_bus) begin
                        s_d.p1_reg = apb_req.pwdata[7:0];
                    end
                end
                ADDR_PORT3_CFG: s_d.p3cfg = apb_req.pwdata[7:0];
                ADDR_BUS_MODE: s_d.mode = apb_req.pwdata[7:0];
                ADDR_BUS_ADDR: s_d.bus_addr = apb_req.pwdata[15:0];
                ADDR_BUS_DATA: s_d.wdata = apb_req.pwdata[15:8];
                ADDR_CMD: begin
                    // a command while a cycle runs is dropped
                    if (!s_q.busy) begin
                        s_d.cmd = new_cmd;
                        s_d.internal = 1'b0;
                        case (new_cmd)
                            CMD_FETCH: begin
                                go_addr = s_q.pc;
                                if (s_q.pf_valid) begin
                                    // overlapped opcode is ready at once
                                    s_d.opcode = s_q.prefetch;
                                    s_d.pf_valid = 1'b0;
                                    go = !apb_req.pwdata[CMD_LONG_BIT];
                                    s_d.to_prefetch = 1'b1;
                                end else begin
                                    go = 1'b1;
                                    s_d.to_prefetch = 1'b0;
                                end
                                go_cmd = CMD_FETCH;
                            end
                            CMD_PUSH, CMD_POP: begin
                                if (s_q.mode[MODE_STACK_INT]) begin
                                    s_d.internal = 1'b1;
                                end else begin
                                    s_d.pf_valid = 1'b0;
                                    go = 1'b1;
                                    go_cmd = new_cmd;
                                end
                            end
                            CMD_NONE: s_d.cmd = CMD_NONE;
                            default: begin
                                // memory reference empties the pipe
                                s_d.pf_valid = 1'b0;
                                go = 1'b1;
                                go_cmd = new_cmd;
                            end
                        endcase
                    end
                end
                default: begin
                end
            endcase
        end

        // machine cycle sequencing, 6 or 8 internal clock periods
        if (tick && (s_q.st != ST_IDLE)) begin
            case (s_q.st)
                ST_ADDR: begin
                    if (s_q.cnt == ADDR_LAST) begin
                        // address phase over: drive write data or release
                        s_d.st = ST_XFER;
                        s_d.cnt = 2'd0;
                        s_d.pins.port1_out = s_q.wdata;
                        s_d.pins.port1_oe = !s_q.pins.read_write_n;
                    end else begin
                        s_d.pins.address_strobe_n = 1'b1;
                        s_d.cnt = s_q.cnt + 2'd1;
                    end
                end
                ST_XFER: begin
                    if (s_q.cnt == 2'd0) begin
                        // data strobe only for external references
                        s_d.pins.data_strobe_n = s_q.internal;
                    end
                    if (s_q.cnt == xfer_last) begin
                        s_d.st = ST_END;
                        s_d.cnt = 2'd0;
                    end else begin
                        s_d.cnt = s_q.cnt + 2'd1;
                    end
                end
                ST_END: begin
                    if (s_q.cnt == 2'd0) begin
                        // sample the bus before the strobe rises
                        s_d.rdata = s_q.internal ? INT_READ_VALUE : p1_pin;
                        s_d.pins.data_strobe_n = 1'b1;
                        s_d.cnt = s_q.cnt + 2'd1;
                    end else if (s_q.cnt == END_LAST) begin
                        s_d.st = ST_IDLE;
                        s_d.cnt = 2'd0;
                        s_d.busy = 1'b0;
                        s_d.pins.read_write_n = 1'b1;
                        s_d.pins.port1_oe = 1'b0;
                        s_d.pins.data_space_select_n = 1'b1;
                        if (s_q.cmd == CMD_FETCH) begin
                            s_d.pc = s_q.pc + 16'h0001;
                            if (s_q.to_prefetch) begin
                                s_d.prefetch = s_q.rdata;
                                s_d.pf_valid = 1'b1;
                            end else begin
                                s_d.opcode = s_q.rdata;
                                go = 1'b1; // refill the pipe at once
                                go_cmd = CMD_FETCH;
                                go_addr = s_q.pc + 16'h0001;
                                s_d.to_prefetch = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    s_d.st = ST_IDLE;
                end
            endcase
        end

        // start a machine cycle after sequencing, so a chained prefetch
        // overrides the idle levels that the ending cycle set
        go_write = (go_cmd == CMD_PROG_WRITE) ||
            (go_cmd == CMD_DATA_WRITE) || (go_cmd == CMD_PUSH);
        go_data = (go_cmd == CMD_DATA_READ) || (go_cmd == CMD_DATA_WRITE) ||
            (go_cmd == CMD_PUSH) || (go_cmd == CMD_POP);
        go_int = (VARIANT == VAR_ROM) && ({1'b0, go_addr} < INT_ROM_LIMIT) &&
            ((go_cmd == CMD_FETCH) || (go_cmd == CMD_PROG_READ));
        if (go) begin
            s_d.busy = 1'b1;
            s_d.st = ST_ADDR;
            s_d.cnt = 2'd0;
            s_d.cyc_addr = go_addr;
            s_d.internal = go_int;
            s_d.ext = s_q.mode[MODE_EXT_TIMING] && !go_int;
            s_d.pins.address_strobe_n = 1'b0;
            s_d.pins.port1_out = go_addr[7:0];
            s_d.pins.port1_oe = 1'b1;
            s_d.pins.read_write_n = !(go_write && !go_int);
            s_d.pins.data_space_select_n = !(dm_en && go_data);
        end

        // port 0 pins: address nibbles hold the cycle address throughout
        for (int n = 0; n < 2; n++) begin
            pair = s_q.mode[P0_NIBBLE_STRIDE * n +: 2];
            if (pair[1]) begin
                s_d.pins.port0_out[4 * n +: 4] =
                    s_d.cyc_addr[8 + 4 * n +: 4];
                s_d.pins.port0_oe[4 * n +: 4] = 4'hf;
            end else begin
                s_d.pins.port0_out[4 * n +: 4] = s_q.p0_reg[4 * n +: 4];
                s_d.pins.port0_oe[4 * n +: 4] =
                    (pair == PAIR_OUT) ? 4'hf : 4'h0;
            end
        end

        // port 1 as plain I/O when it is not the bus
        if (!p1_bus) begin
            s_d.pins.port1_out = s_q.p1_reg;
            s_d.pins.port1_oe = (s_q.mode[MODE_P1_LSB +: 2] == PAIR_OUT);
        end
        s_d.pins.data_space_select_oe = dm_en;
    end

    // all control state, reset to the flavour's defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.mode <= MODE_RST;
            s_q.p3cfg <= P3_CFG_RST;
            s_q.p0_reg <= PORT_RST;
            s_q.p1_reg <= PORT_RST;
            s_q.pc <= PC_RST;
            s_q.cyc_addr <= PC_RST;
            s_q.cmd <= CMD_NONE;
            s_q.pins.address_strobe_n <= 1'b1;
            s_q.pins.data_strobe_n <= 1'b1;
            s_q.pins.read_write_n <= 1'b1;
            s_q.pins.data_space_select_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp = s_q.rsp;
    assign pins = s_q.pins;
endmodule : ext_bus_ctrl

// ---- tb/mem_model.sv ----
`timescale 1ns/1ns
module mem_model
(
    input wire logic pclk,
    input ext_bus_pkg::bus_pins_t pins,
    output logic [7:0] port1_in
);
    import ext_bus_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] addr_q;
    logic rd_win = 1'b0;
    initial port1_in = 8'h00;
    // latch low address on the strobe, port 1 drops it afterwards
    always @(posedge pins.address_strobe_n) begin
        addr_q = pins.port1_out;
        rd_win = 1'b1;
    end
    // answer as soon as the bus is released: the pin synchroniser needs
    // the byte early to settle within a normal-length data strobe;
    // scramble lines otherwise so stale data never passes
    always @(posedge pclk) begin
        if (rd_win && pins.read_write_n && !pins.port1_oe)
            port1_in <= mem[addr_q];
        else
            port1_in <= ~port1_in;
    end
    // store write data as the data strobe rises; the cycle is over
    always @(posedge pins.data_strobe_n) begin
        if (!pins.read_write_n) mem[addr_q] = pins.port1_out;
        rd_win = 1'b0;
    end
endmodule : mem_model

// ---- tb/ext_bus_ctrl_asserts.sv ----
`timescale 1ns/1ns
module ext_bus_ctrl_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input ext_bus_pkg::apb_req_t apb_req,
    input ext_bus_pkg::apb_rsp_t apb_rsp,
    input wire logic [7:0] port0_in,
    input wire logic [7:0] port1_in,
    input ext_bus_pkg::bus_pins_t pins
);
    import ext_bus_pkg::*;
    // short names for the strobes and the direction line
    wire as_n = pins.address_strobe_n;
    wire ds_n = pins.data_strobe_n;
    wire rw_n = pins.read_write_n;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_as_pulse: assert property ($fell(as_n) |-> ##[1:3] as_n[*8])
        else $error("address strobe pulse wrong");
    chk_ds_width: assert property ($fell(ds_n) |->
        (!ds_n[*4] ##1 ds_n) or (!ds_n[*8] ##1 ds_n))
        else $error("data strobe width wrong");
    chk_rd_release: assert property ($fell(ds_n) && rw_n |->
        !pins.port1_oe) else $error("bus not released");
    chk_wr_data: assert property (!ds_n && !rw_n |->
        pins.port1_oe && $stable(pins.port1_out))
        else $error("write data not held");
    chk_rw_ext: assert property ($fell(rw_n) |-> ##[4:8] !ds_n)
        else $error("write without data strobe");
    chk_p1_addr: assert property ($fell(as_n) |=>
        ($stable(pins.port1_out) && pins.port1_oe)[*2])
        else $error("low address not held");
    chk_p0_stable: assert property (!ds_n |-> $stable(pins.port0_out))
        else $error("upper address moved");
    chk_rst_idle: assert property ($rose(presetn) |->
        as_n && ds_n && rw_n) else $error("strobes active after reset");
    cover property ($fell(ds_n) && !rw_n);
    cover property (!ds_n[*8]);
    cover property (!pins.data_space_select_n);
endmodule : ext_bus_ctrl_asserts
bind ext_bus_ctrl ext_bus_ctrl_asserts i_chk (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .port0_in(port0_in), .port1_in(port1_in), .pins(pins));

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import ext_bus_pkg::*;
    logic pclk, presetn, err;
    apb_req_t rq;
    apb_rsp_t rs;
    logic [7:0] p1;
    bus_pins_t pins;
    logic [31:0] rd;
    int fails = 0, n_compared = 0, ds_cnt = 0, dm_cnt = 0;
    ext_bus_ctrl #(.VARIANT(VAR_ROMLESS_A)) i_dut (.pclk(pclk),
        .presetn(presetn), .apb_req(rq), .apb_rsp(rs), .port0_in(8'ha3),
        .port1_in(p1), .pins(pins));
    mem_model i_mem (.pclk(pclk), .pins(pins), .port1_in(p1));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // strobe lengths are measured here, not taken from the design
    always @(posedge pclk) begin
        if (!pins.data_strobe_n) ds_cnt++;
        if (!pins.data_space_select_n) dm_cnt++;
    end
    task automatic ck(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : ck
    // one apb transfer; a spare cycle after release avoids double drives
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        rq <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        rq.penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do @(posedge pclk); while (rs.pready !== 1'b1);
        rd = rs.prdata;
        err = rs.pslverr;
        rq <= '0;
        @(posedge pclk);
    endtask : apb
    task automatic run(input logic [2:0] c);
        int n;
        n = 0;
        ds_cnt = 0;
        dm_cnt = 0;
        apb(1'b1, ADDR_CMD, {29'h0, c});
        do apb(1'b0, ADDR_STATUS, 0); while (rd[0] !== 1'b0 && ++n < 40);
        ck(rd[0], 1'b0);
    endtask : run
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        presetn = 1'b0;
        rq = '0;
        // opcodes at the reset start address
        i_mem.mem[8'h0c] = 8'h3c;
        i_mem.mem[8'h0d] = 8'hc3;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 0);
        ck(rd[31:16], PC_RST_A);
        ck(pins.port0_oe, 8'h00);
        apb(1'b0, ADDR_BUS_MODE, 0);
        ck(rd, 0);
        apb(1'b0, 12'h800, 0);
        ck(err, 1);
        $display("reset test done");
        run(CMD_FETCH);
        ck(rd[31:16], PC_RST_A + 16'd2);
        ck(rd[1], 1'b1);
        apb(1'b0, ADDR_OPCODE, 0);
        ck(rd[15:0], 16'hc33c);
        $display("fetch test done");
        apb(1'b1, ADDR_PORT3_CFG, 32'h10);
        apb(1'b1, ADDR_BUS_ADDR, 32'h34);
        apb(1'b1, ADDR_BUS_DATA, 32'h5a00);
        run(CMD_DATA_WRITE);
        ck(rd[1], 1'b0);
        ck(ds_cnt, 8);
        ck(dm_cnt != 0, 1);
        ck(i_mem.mem[8'h34], 8'h5a);
        apb(1'b1, ADDR_PORT0, 32'h00);
        apb(1'b1, ADDR_BUS_MODE, 32'h52);
        run(CMD_DATA_READ);
        ck(ds_cnt, 4);
        apb(1'b0, ADDR_BUS_DATA, 0);
        ck(rd[7:0], 8'h5a);
        apb(1'b0, ADDR_PORT0, 0);
        ck(rd[7:0], 8'haf);
        ck(pins.port0_oe, 8'h0f);
        $display("bus test done");
        apb(1'b1, ADDR_BUS_DATA, 32'h6600);
        run(CMD_PUSH);
        ck(dm_cnt != 0, 1);
        run(CMD_POP);
        apb(1'b0, ADDR_BUS_DATA, 0);
        ck(rd[7:0], 8'h66);
        apb(1'b1, ADDR_BUS_MODE, 32'h56);
        run(CMD_DATA_READ);
        ck(ds_cnt, 4);
        run(CMD_PUSH);
        ck(ds_cnt, 0);
        ck(rd[2], 1);
        $display("stack test done");
        results();
    end
    // cut a hang short well past the expected run length
    initial begin
        #100000;
        fails++;
        results();
    end
endmodule : tb_top
